// >>> hw/radio_spi_pkg.sv
package radio_spi_pkg;

   // ****************************************
   // Sizes of the register space and buffer
   // ****************************************
   localparam int           REG_COUNT     = 64;
   localparam int           BUF_DEPTH     = 128;
   localparam int           MAX_FRAME_LEN = 127;
   localparam int           FIFO_DEPTH    = 2;

   // ****************************************
   // Control register and status source
   // ****************************************
   localparam logic [5:0]   CTRL_ADDR      = 6'h04;
   localparam logic [7:0]   CTRL_RESET     = 8'h22;
   localparam int           STATUS_SRC_LSB = 2;
   localparam int           STATUS_SRC_MSB = 3;
   localparam logic [1:0]   SRC_ZERO       = 2'h0;
   localparam logic [1:0]   SRC_TRX_STATE  = 2'h1;
   localparam logic [1:0]   SRC_RSSI       = 2'h2;
   localparam logic [1:0]   SRC_IRQ        = 2'h3;

   // ****************************************
   // Command byte layout
   // ****************************************
   localparam int           CMD_REG_BIT    = 7;
   localparam int           CMD_WRITE_BIT  = 6;
   localparam logic [2:0]   CMD_FRAME_RD   = 3'h1;
   localparam logic [2:0]   CMD_FRAME_WR   = 3'h3;
   localparam logic [2:0]   CMD_SRAM_RD    = 3'h0;
   localparam logic [2:0]   CMD_SRAM_WR    = 3'h2;
   localparam logic [2:0]   LAST_BIT       = 3'h7;

   // ****************************************
   // Frame read trailer offsets past length, frame write end address
   // ****************************************
   localparam logic [7:0]   OFS_LQI        = 8'h01;
   localparam logic [7:0]   OFS_ED         = 8'h02;
   localparam logic [7:0]   OFS_RX_STATUS  = 8'h03;
   localparam logic [7:0]   FB_ADDR_END    = 8'h80;

   typedef enum logic [2:0] {
      PH_IDLE     = 3'b000,
      PH_CMD      = 3'b001,
      PH_REG_RD   = 3'b010,
      PH_REG_WR   = 3'b011,
      PH_FRAME_RD = 3'b100,
      PH_FRAME_WR = 3'b101,
      PH_SRAM     = 3'b110,
      PH_DONE     = 3'b111
   } phase_t;

   typedef struct packed {
      logic [7:0] lqi;
      logic [7:0] ed;
      logic       crc_valid;
      logic [2:0] trac;
   } rx_meta_t;

   typedef struct packed {
      logic [7:0] trx_state;
      logic [7:0] rssi;
      logic [7:0] irq_status;
   } status_src_t;

   typedef struct packed {
      logic       is_frame;
      logic [6:0] addr;
      logic [7:0] data;
   } wr_req_t;

endpackage

// >>> hw/radio_spi_slave.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (R01) Master opens with command byte, MSB first
// (R02) Top bit set: register access, bit6 write
// (R03) Top three bits select frame/SRAM mode
// (R04) Register space spans 64 byte locations
// (R05) Register access is two bytes; read returns data
// (R06) Register write stores second MOSI byte
// (R07) First MISO byte zero after reset, selectable
// (R08) Master ignores don't-care MISO bytes
// (R09) Master releases select after register access
// (R10) Frame access restarts buffer address at zero
// (R11) 128-byte frame buffer holds one frame
// (R12) Frame read: length, payload, three trailer bytes
// (R13) Receive status: CRC bit7, result bits6..4
// (R14) Master sends length byte then payload
// (R15) Read 5+len, write 2+len, len<=127
// (R16) Each data byte advances buffer address
// (R17) Frame read abort harmless, restarts at length
// (R18) New receive or write replaces buffer content
// (R19) Mode 0: sample rising, shift falling
// (R20) Select low starts transfer, enables MISO
// (R21) Status source 0 zero,1 state,2 rssi,3 irq
// (R22) Frame read ignores MOSI, never writes buffer
module radio_spi_slave
   import radio_spi_pkg::*;
(
   input  wire logic        clk,                     // 200 MHz core clock
   input  wire logic        rst_b,                   // Synchronous reset, active low
   input  wire logic        sclk,                    // Serial clock pin from master
   input  wire logic        sel_b,                   // Chip select pin, active low
   input  wire logic        mosi,                    // Serial data in pin
   output var  logic        miso,                    // Serial data out
   output var  logic        miso_oe,                 // Serial data out driver enable
   input  wire status_src_t status_src,              // Sources for the leading status byte
   input  wire logic        rx_wr_valid,             // Radio writes a received byte
   input  wire logic [6:0]  rx_wr_addr,              // Buffer address of received byte
   input  wire logic [7:0]  rx_wr_data,              // Received byte
   input  wire logic        rx_done,                 // Received frame complete
   input  wire rx_meta_t    rx_meta,                 // Trailer values of received frame
   output var  logic [7:0]  transceiver_control_one, // Control register contents
   output var  logic        spi_overrun              // Write byte lost to full buffer
);
   localparam int                PTR_W    = $clog2(FIFO_DEPTH);
   localparam logic [PTR_W-1:0]  LAST_PTR = PTR_W'(FIFO_DEPTH - 1);
   localparam logic [PTR_W:0]    FULL_CNT = (PTR_W + 1)'(FIFO_DEPTH);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic sclk_s1, sclk_s2, sclk_s3;
   logic sel_s1, sel_s2, sel_s3;
   logic mosi_s1, mosi_s2;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
         {sel_s1, sel_s2, sel_s3}    <= 3'h7;
         {mosi_s1, mosi_s2}          <= 2'h0;
      end else begin
         {sclk_s1, sclk_s2, sclk_s3} <= {sclk, sclk_s1, sclk_s2};
         {sel_s1, sel_s2, sel_s3}    <= {sel_b, sel_s1, sel_s2};
         {mosi_s1, mosi_s2}          <= {mosi, mosi_s1};
      end
   end
   logic sclk_rise, sclk_fall, sel_start;
   assign sclk_rise = sclk_s2 && !sclk_s3;  // see R19
   assign sclk_fall = !sclk_s2 && sclk_s3;
   assign sel_start = !sel_s2 && sel_s3;    // see R20

   // ****************************************
   // Storage
   // ****************************************
   logic [7:0] regs [REG_COUNT];  // see R04
   logic [7:0] fbuf [BUF_DEPTH];  // see R11
   rx_meta_t   meta;
   wr_req_t    fifo_mem [FIFO_DEPTH];
   logic [PTR_W-1:0] wptr, rptr;
   logic [PTR_W:0]   fifo_cnt;
   logic [7:0]       rx_shift, next_rx_shift;
   logic [7:0]       fb_addr, next_fb_addr;
   assign transceiver_control_one = regs[CTRL_ADDR];

   // ****************************************
   // Leading status byte and frame read data
   // ****************************************
   logic [7:0] status_now, frame_byte, rx_status_byte, len8, byte_full;
   always_comb begin
      case (transceiver_control_one[STATUS_SRC_MSB:STATUS_SRC_LSB])  // see R21
         SRC_ZERO:      status_now = 8'h00;                          // see R07
         SRC_TRX_STATE: status_now = status_src.trx_state;
         SRC_RSSI:      status_now = status_src.rssi;
         SRC_IRQ:       status_now = status_src.irq_status;
         default:       status_now = 8'h00;
      endcase
   end
   assign rx_status_byte = {meta.crc_valid, meta.trac, 4'h0};  // see R13
   assign len8           = {1'b0, fbuf[0][6:0]};
   assign byte_full      = {rx_shift[6:0], mosi_s2};
   always_comb begin
      if (fb_addr <= len8) begin
         frame_byte = fbuf[fb_addr[6:0]];                         // see R12
      end else if (fb_addr == len8 + OFS_LQI) begin
         frame_byte = meta.lqi;
      end else if (fb_addr == len8 + OFS_ED) begin
         frame_byte = meta.ed;
      end else if (fb_addr == len8 + OFS_RX_STATUS) begin
         frame_byte = rx_status_byte;
      end else begin
         frame_byte = 8'h00;
      end
   end

   // ****************************************
   // Serial engine
   // ****************************************
   phase_t     phase, next_phase;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [5:0] reg_addr, next_reg_addr;
   logic [7:0] tx_shift, next_tx_shift;
   logic [7:0] tx_next, next_tx_next;
   logic       next_miso, next_miso_oe, next_overrun;
   logic       byte_done, push_want, push;
   wr_req_t    push_req;
   logic       fifo_in_ready, fifo_out_valid, drain;
   wr_req_t    head;
   assign byte_done = !sel_s2 && !sel_start && sclk_rise && (bit_cnt == LAST_BIT);
   always_comb begin
      next_phase    = phase;
      next_bit_cnt  = bit_cnt;
      next_rx_shift = rx_shift;
      next_reg_addr = reg_addr;
      next_fb_addr  = fb_addr;
      next_tx_shift = tx_shift;
      next_tx_next  = tx_next;
      next_miso     = miso;
      next_miso_oe  = !sel_s2;                                   // see R20
      next_overrun  = spi_overrun;
      push_want     = 1'b0;
      push_req      = '0;
      if (sel_s2) begin
         next_phase   = PH_IDLE;                                 // see R17
         next_bit_cnt = 3'h0;
      end else if (sel_start) begin
         next_phase    = PH_CMD;                                 // see R01
         next_bit_cnt  = 3'h0;
         next_miso     = status_now[7];                          // see R07
         next_tx_shift = {status_now[6:0], 1'b0};
         next_tx_next  = 8'h00;
         next_overrun  = 1'b0;
      end else begin
         if (sclk_rise) begin
            next_rx_shift = byte_full;                           // see R19
            next_bit_cnt  = bit_cnt + 3'h1;
         end
         if (byte_done) begin
            next_tx_next = 8'h00;                                // see R08
            case (phase)
               PH_CMD: begin
                  if (byte_full[CMD_REG_BIT]) begin              // see R02
                     next_reg_addr = byte_full[5:0];
                     next_tx_next  = regs[byte_full[5:0]];       // see R05
                     next_phase    = byte_full[CMD_WRITE_BIT] ? PH_REG_WR : PH_REG_RD;
                  end else begin
                     case (byte_full[7:5])                       // see R03
                        CMD_FRAME_RD: begin
                           next_phase   = PH_FRAME_RD;
                           next_tx_next = fbuf[0];               // see R10
                           next_fb_addr = 8'h01;
                        end
                        CMD_FRAME_WR: begin
                           next_phase   = PH_FRAME_WR;
                           next_fb_addr = 8'h00;                 // see R10
                        end
                        default: next_phase = PH_SRAM;           // Random access decoded only
                     endcase
                  end
               end
               PH_REG_WR: begin
                  push_want  = 1'b1;                             // see R06
                  push_req   = '{is_frame: 1'b0, addr: {1'b0, reg_addr}, data: byte_full};
                  next_phase = PH_DONE;                          // see R05
               end
               PH_FRAME_RD: begin
                  next_tx_next = frame_byte;                     // see R22
                  if (fb_addr != 8'hFF) begin
                     next_fb_addr = fb_addr + 8'h01;             // see R16
                  end
               end
               PH_FRAME_WR: begin
                  if (fb_addr < FB_ADDR_END) begin               // see R15
                     push_want    = 1'b1;                        // see R14
                     push_req     = '{is_frame: 1'b1, addr: fb_addr[6:0], data: byte_full};
                     next_fb_addr = fb_addr + 8'h01;             // see R16
                  end
               end
               default: ;
            endcase
         end
         if (sclk_fall) begin
            next_miso     = (bit_cnt == 3'h0) ? tx_next[7] : tx_shift[7];                          // see R19
            next_tx_shift = (bit_cnt == 3'h0) ? {tx_next[6:0], 1'b0} : {tx_shift[6:0], 1'b0};
         end
      end
      push         = push_want && fifo_in_ready;
      next_overrun = next_overrun || (push_want && !fifo_in_ready);
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         phase       <= PH_IDLE;
         bit_cnt     <= 3'h0;
         rx_shift    <= 8'h00;
         reg_addr    <= 6'h00;
         fb_addr     <= 8'h00;
         tx_shift    <= 8'h00;
         tx_next     <= 8'h00;
         miso        <= 1'b0;
         miso_oe     <= 1'b0;
         spi_overrun <= 1'b0;
      end else begin
         phase       <= next_phase;
         bit_cnt     <= next_bit_cnt;
         rx_shift    <= next_rx_shift;
         reg_addr    <= next_reg_addr;
         fb_addr     <= next_fb_addr;
         tx_shift    <= next_tx_shift;
         tx_next     <= next_tx_next;
         miso        <= next_miso;
         miso_oe     <= next_miso_oe;
         spi_overrun <= next_overrun;
      end
   end

   // ****************************************
   // Two-entry write buffer
   // ****************************************
   // Radio receive has the buffer port first, so draining stalls while it writes
   logic [PTR_W-1:0] next_wptr, next_rptr;
   logic [PTR_W:0]   next_fifo_cnt;
   assign head           = fifo_mem[rptr];
   assign fifo_in_ready  = (fifo_cnt != FULL_CNT);
   assign fifo_out_valid = (fifo_cnt != '0);
   assign drain          = fifo_out_valid && !rx_wr_valid;       // see R18
   always_comb begin
      next_wptr     = push ? ((wptr == LAST_PTR) ? '0 : wptr + PTR_W'(1)) : wptr;
      next_rptr     = drain ? ((rptr == LAST_PTR) ? '0 : rptr + PTR_W'(1)) : rptr;
      next_fifo_cnt = fifo_cnt + (PTR_W + 1)'(push) - (PTR_W + 1)'(drain);
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wptr     <= '0;
         rptr     <= '0;
         fifo_cnt <= '0;
      end else begin
         wptr     <= next_wptr;
         rptr     <= next_rptr;
         fifo_cnt <= next_fifo_cnt;
      end
      if (push) begin
         fifo_mem[wptr] <= push_req;
      end
   end

   // ****************************************
   // Register file, frame buffer, trailer
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            regs[i] <= (i == int'(CTRL_ADDR)) ? CTRL_RESET : 8'h00;
         end
         meta <= '0;                                             // see R13
      end else begin
         if (drain && !head.is_frame) begin
            regs[head.addr[5:0]] <= head.data;                   // see R06
         end
         if (rx_done) begin
            meta <= rx_meta;
         end
      end
      if (rx_wr_valid) begin
         fbuf[rx_wr_addr] <= rx_wr_data;                         // see R18
      end else if (drain && head.is_frame) begin
         fbuf[head.addr] <= head.data;                           // see R18
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   logic [5:0] last_head_addr;
   logic [7:0] stored_now;
   always_ff @(posedge clk) begin
      last_head_addr <= head.addr[5:0];
   end
   assign stored_now = regs[last_head_addr];
   property p_oe_on_select;
      sel_start |=> miso_oe ##1 (miso_oe throughout (!sel_s2)[*2]);
   endproperty
   a_oe_on_select: assert property (p_oe_on_select) else $error("MISO driver not enabled"); // see R20
   property p_zero_status;
      (sel_start && transceiver_control_one[STATUS_SRC_MSB:STATUS_SRC_LSB] == SRC_ZERO) |=> !miso;
   endproperty
   a_zero_status: assert property (p_zero_status) else $error("Status bit not zero"); // see R07
   property p_reg_decode;
      (byte_done && phase == PH_CMD && byte_full[7]) |=>
         phase == ($past(byte_full[6]) ? PH_REG_WR : PH_REG_RD) && reg_addr == $past(byte_full[5:0]);
   endproperty
   a_reg_decode: assert property (p_reg_decode) else $error("Register command misdecoded"); // see R02
   property p_frame_rd_start;
      (byte_done && phase == PH_CMD && byte_full[7:5] == CMD_FRAME_RD) |=> phase == PH_FRAME_RD && fb_addr == 8'h01;
   endproperty
   a_frame_rd_start: assert property (p_frame_rd_start) else $error("Frame read start wrong"); // see R03
   property p_reg_store;
      (drain && !head.is_frame) |=> stored_now == $past(head.data);
   endproperty
   a_reg_store: assert property (p_reg_store) else $error("Register write lost"); // see R06
   property p_addr_step;
      (byte_done && phase == PH_FRAME_RD && fb_addr < 8'hFF) |=> fb_addr == $past(fb_addr) + 8'h01;
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("Buffer address not advanced"); // see R16
   property p_read_no_write;
      phase == PH_FRAME_RD |-> !push;
   endproperty
   a_read_no_write: assert property (p_read_no_write) else $error("Frame read wrote buffer"); // see R22
   property p_abort_idle;
      sel_s2 |=> phase == PH_IDLE && bit_cnt == 3'h0;
   endproperty
   a_abort_idle: assert property (p_abort_idle) else $error("Deselect did not end access"); // see R17
   property p_lqi_trailer;
      (byte_done && phase == PH_FRAME_RD && fb_addr == len8 + OFS_LQI) |=> tx_next == meta.lqi;
   endproperty
   a_lqi_trailer: assert property (p_lqi_trailer) else $error("Trailer byte wrong"); // see R12

endmodule

`default_nettype wire

// >>> verification/spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
   input  wire logic clk,     // Core clock, tracks the last driven miso
   input  wire logic miso,    // Serial data from the slave
   input  wire logic miso_oe, // Slave driver enable
   output var  logic sclk,    // Serial clock, idle low
   output var  logic sel_b,   // Chip select, active low
   output var  logic mosi     // Serial data to the slave
);
   // ****************************************
   // Line resolution
   // ****************************************
   realtime   half_ns = 62.5;
   logic      last_miso = 1'b0;
   wire logic miso_line;

   always @(posedge clk) begin
      if (miso_oe) begin
         last_miso <= miso;
      end
   end
   // No pull-up: a released line shows the inverse, never a stale match
   assign miso_line = miso_oe ? miso : ~last_miso;

   initial begin
      sclk = 1'b0;
      sel_b = 1'b1;
      mosi = 1'b0;
   end

   // ****************************************
   // Frame and byte tasks
   // ****************************************
   task automatic start();
      sel_b = 1'b0;
      #(half_ns);
   endtask

   task automatic stop();
      #(half_ns);
      sel_b = 1'b1;
      mosi = ~mosi;
      #100;
   endtask

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi = tx[i];
         #(half_ns);
         sclk = 1'b1;
         rx[i] = miso_line;
         #(half_ns);
         sclk = 1'b0;
      end
   endtask
endmodule

`default_nettype wire

// >>> verification/radio_spi_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none

module radio_spi_slave_tb;
   import radio_spi_pkg::*;

   logic        clk;
   logic        rst_b;
   logic        sclk;
   logic        sel_b;
   logic        mosi;
   logic        miso;
   logic        miso_oe;
   status_src_t status_src;
   logic        rx_wr_valid;
   logic [6:0]  rx_wr_addr;
   logic [7:0]  rx_wr_data;
   logic        rx_done;
   rx_meta_t    rx_meta;
   logic [7:0]  transceiver_control_one;
   logic        spi_overrun;
   logic [7:0]  st;
   logic [7:0]  q;
   logic [7:0]  tx_b [$];
   logic [7:0]  rx_b [$];
   logic [7:0]  ex_b [$];
   int          n_mismatch = 0;
   int          n_checks = 0;

   radio_spi_slave dut_u (.clk(clk), .rst_b(rst_b), .sclk(sclk), .sel_b(sel_b), .mosi(mosi), .miso(miso),
      .miso_oe(miso_oe), .status_src(status_src), .rx_wr_valid(rx_wr_valid), .rx_wr_addr(rx_wr_addr),
      .rx_wr_data(rx_wr_data), .rx_done(rx_done), .rx_meta(rx_meta),
      .transceiver_control_one(transceiver_control_one), .spi_overrun(spi_overrun));

   spi_master_model m_u (.clk(clk), .miso(miso), .miso_oe(miso_oe), .sclk(sclk), .sel_b(sel_b), .mosi(mosi));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ****************************************
   // Compare and access tasks
   // ****************************************
   task automatic final_report();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic reg_xfer(input logic [7:0] cmd, input logic [7:0] d);
      m_u.start();
      m_u.xfer(cmd, st);
      m_u.xfer(d, q);
      m_u.stop();
   endtask

   task automatic frame();
      logic [7:0] b;
      m_u.start();
      chk1(miso_oe, 1'b1);
      rx_b = {};
      foreach (tx_b[i]) begin
         m_u.xfer(tx_b[i], b);
         rx_b.push_back(b);
      end
      m_u.stop();
      chk1(miso_oe, 1'b0);
   endtask

   task automatic chk_rx();
      foreach (ex_b[i]) begin
         chk8(rx_b[i], ex_b[i]);
      end
   endtask

   task automatic radio_wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      rx_wr_valid = 1'b1;
      rx_wr_addr = a;
      rx_wr_data = d;
      @(posedge clk);
      #1;
      rx_wr_valid = 1'b0;
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      rst_b = 1'b0;
      status_src = '{trx_state: 8'h96, rssi: 8'h3B, irq_status: 8'hE1};
      rx_wr_valid = 1'b0;
      rx_wr_addr = 7'h00;
      rx_wr_data = 8'h00;
      rx_done = 1'b0;
      rx_meta = '0;
      repeat (5) @(posedge clk);
      #1;
      rst_b = 1'b1;
      repeat (5) @(posedge clk);
      chk8(transceiver_control_one, 8'h22);
      chk1(miso_oe, 1'b0);
      reg_xfer(8'h84, 8'hFF);
      chk8(st, 8'h00);
      chk8(q, 8'h22);
      reg_xfer(8'hFF, 8'hA5);
      reg_xfer(8'hC0, 8'h5C);
      reg_xfer(8'hBF, 8'h00);
      chk8(q, 8'hA5);
      reg_xfer(8'h80, 8'h00);
      chk8(q, 8'h5C);
      for (int s = 0; s < 4; s++) begin
         reg_xfer(8'hC4, 8'h20 | 8'(s << 2));
         chk8(transceiver_control_one, 8'h20 | 8'(s << 2));
         reg_xfer(8'h84, 8'h00);
         chk8(st, (s == 0) ? 8'h00 : (s == 1) ? 8'h96 : (s == 2) ? 8'h3B : 8'hE1);
      end
      reg_xfer(8'hC4, 8'h20);
      // Frame write, then read with MOSI held high and no receive yet
      tx_b = '{8'h60, 8'h03, 8'hA1, 8'hB2, 8'hC3};
      frame();
      chk1(spi_overrun, 1'b0);
      tx_b = '{8'h20, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
      ex_b = '{8'h00, 8'h03, 8'hA1, 8'hB2, 8'hC3, 8'h00, 8'h00, 8'h00};
      frame();
      chk_rx();
      tx_b = '{8'h20, 8'h00};
      ex_b = '{8'h00, 8'h03};
      frame();
      chk_rx();
      rx_meta = '{lqi: 8'h5A, ed: 8'h3C, crc_valid: 1'b1, trac: 3'h5};
      @(posedge clk);
      #1;
      rx_done = 1'b1;
      @(posedge clk);
      #1;
      rx_done = 1'b0;
      // Slow master on this pass
      m_u.half_ns = 150.0;
      tx_b = '{8'h20, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
      ex_b = '{8'h00, 8'h03, 8'hA1, 8'hB2, 8'hC3, 8'h5A, 8'h3C, 8'hD0};
      frame();
      chk_rx();
      m_u.half_ns = 62.5;
      radio_wr(7'h00, 8'h02);
      radio_wr(7'h01, 8'h11);
      radio_wr(7'h02, 8'h22);
      tx_b = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      ex_b = '{8'h00, 8'h02, 8'h11, 8'h22, 8'h5A, 8'h3C, 8'hD0};
      frame();
      chk_rx();
      // Random-access commands are decoded but leave the buffer alone
      tx_b = '{8'h00, 8'h01, 8'hFF};
      ex_b = '{8'h00, 8'h00, 8'h00};
      frame();
      chk_rx();
      tx_b = '{8'h40, 8'h01, 8'h99};
      frame();
      tx_b = '{8'h20, 8'h00, 8'h00};
      ex_b = '{8'h00, 8'h02, 8'h11};
      frame();
      chk_rx();
      // Longest frame reaches the last buffer location
      radio_wr(7'h00, 8'h7F);
      radio_wr(7'h7F, 8'h7E);
      tx_b = {};
      tx_b.push_back(8'h20);
      repeat (131) tx_b.push_back(8'h00);
      frame();
      chk8(rx_b[1], 8'h7F);
      chk8(rx_b[128], 8'h7E);
      chk8(rx_b[129], 8'h5A);
      chk8(rx_b[131], 8'hD0);
      final_report();
   end

   initial begin
      #400us;
      n_mismatch++;
      final_report();
   end
endmodule

`default_nettype wire
